// [mapl_pkg.sv]
// Shared constants and types for the meter converter host-port logic
`default_nettype none
package mapl_pkg;

    // Serial frame: one command byte followed by one data word
    localparam int CMD_W = 8;
    localparam int DATA_W = 16;
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] FIRST_OUT = 5'h08;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    // Register addresses carried in the command byte
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_STAT = 3'h1;
    localparam logic [2:0] ADDR_RES = 3'h2;

    // Field positions
    localparam int CTRL_EXT_BIT = 0;

    // Values after reset
    localparam logic EXT_SEL_RST = 1'b0;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // Master clock: nominal external rate and the internal tick divider
    localparam int REF_CLK_KHZ = 25000;
    localparam int MCLK_NOM_KHZ = 4915;
    localparam int INT_DIV = REF_CLK_KHZ / MCLK_NOM_KHZ;

    // Command byte layout
    typedef struct packed {
        logic rd;
        logic [2:0] addr;
        logic [3:0] spare;
    } mapl_cmd_t;

    // Status word layout
    typedef struct packed {
        logic [13:0] spare;
        logic ready;
        logic low_bat;
    } mapl_stat_t;

endpackage : mapl_pkg
`default_nettype wire

// [mapl_pin_logic.sv]
// Serial host port, end-of-conversion, low-battery and clock select logic
//
// Summary of operation
// - With external clock select set, the modulator tick follows the external clock pin.
// - With external clock select clear, the tick comes from the internal divider and the pin is ignored.
// - A low battery input lights the display symbol and latches the low battery flag high.
// - End-of-conversion goes low when a fresh result sits in the result register.
// - The serial port only works while chip select is low and ignores the clock and input otherwise.
// - While selected, the input bit is captured on every rising serial clock edge.
// - The serial clock may idle high or low between transfers.
// - The output bit changes on each falling serial clock edge.
// - The output is released whenever chip select is high and driven only while selected.
// - Register contents go out only in reply to a read command.
// - After reset the internal oscillator is in use and external clock select is zero.
`timescale 1ns/1ns
`default_nettype none
module mapl_pin_logic #(
    parameter int INT_DIV = mapl_pkg::INT_DIV
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe_n,
    // Clock and battery pins
    input wire logic ext_clk,
    input wire logic low_batt_below,
    // Converter core side
    input wire logic conv_done,
    input wire logic [15:0] conv_result,
    // Status outputs
    output logic eoc_n,
    output logic low_batt_lit,
    output logic external_clock_select,
    output logic mod_tick
);

    // Divider must give a real tick period and fit the 8-bit counter
    if (INT_DIV < 2 || INT_DIV > 256) begin : g_div_check
        $error("INT_DIV must lie between 2 and 256");
    end

    localparam logic [7:0] DIV_TOP = 8'(INT_DIV - 1);

    // ---------------- Link domain (serial clock) ----------------
    logic [4:0] bit_cnt_q;
    logic [14:0] rx_q;
    mapl_pkg::mapl_cmd_t cmd_q;
    logic [15:0] tx_q;
    logic sdo_q;
    logic [15:0] wr_data_q;
    logic wr_tgl_q;
    logic rd_tgl_q;
    logic [2:0] rd_addr_q;
    logic [2:0] wr_addr_q;
    logic [15:0] tx_word;

    // Ref-domain snapshots read by the link, frozen during a frame
    logic [15:0] snap_ctrl_q;
    logic [15:0] snap_stat_q;
    logic [15:0] snap_res_q;

    // Bit counter and input shifter; chip select high holds them cleared
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_q <= 5'h00;
            rx_q <= 15'h0000;
        end else begin
            rx_q <= {rx_q[13:0], sdi};
            if (bit_cnt_q != mapl_pkg::FRAME_BITS) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // Command byte capture on the eighth rising edge
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cmd_q <= '0;
        end else if (bit_cnt_q == mapl_pkg::CMD_LAST) begin
            cmd_q <= mapl_pkg::mapl_cmd_t'({rx_q[6:0], sdi});
        end
    end

    // Frame completion events; these survive between frames, so only
    // the system reset clears them, with a constant
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            wr_data_q <= mapl_pkg::WORD_RST;
            wr_tgl_q <= 1'b0;
            rd_tgl_q <= 1'b0;
            rd_addr_q <= 3'h0;
            wr_addr_q <= 3'h0;
        end else if (!cs_n && bit_cnt_q == mapl_pkg::FRAME_LAST) begin
            if (cmd_q.rd) begin
                rd_addr_q <= cmd_q.addr;
                rd_tgl_q <= ~rd_tgl_q;
            end else begin
                wr_addr_q <= cmd_q.addr;
                wr_data_q <= {rx_q, sdi};
                wr_tgl_q <= ~wr_tgl_q;
            end
        end
    end

    // Word selected for a read reply; unmapped addresses answer zero
    always_comb begin
        if (cmd_q.addr == mapl_pkg::ADDR_CTRL) begin
            tx_word = snap_ctrl_q;
        end else if (cmd_q.addr == mapl_pkg::ADDR_STAT) begin
            tx_word = snap_stat_q;
        end else if (cmd_q.addr == mapl_pkg::ADDR_RES) begin
            tx_word = snap_res_q;
        end else begin
            tx_word = mapl_pkg::WORD_RST;
        end
    end

    // Output shifter on the falling edge; working from edges alone
    // means either idle level of the serial clock is fine
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            tx_q <= mapl_pkg::WORD_RST;
            sdo_q <= 1'b0;
        end else if (cmd_q.rd && bit_cnt_q == mapl_pkg::FIRST_OUT) begin
            tx_q <= {tx_word[14:0], 1'b0};
            sdo_q <= tx_word[15];
        end else if (cmd_q.rd && bit_cnt_q > mapl_pkg::FIRST_OUT) begin
            tx_q <= {tx_q[14:0], 1'b0};
            sdo_q <= tx_q[15];
        end else begin
            sdo_q <= 1'b0;
        end
    end

    // Pin drive; enable taken straight from the select pin for fast release
    assign sdo_o = sdo_q;
    assign sdo_oe_n = cs_n;

    // ---------------- System domain (ref_clk) ----------------
    logic cs_s1_q, cs_s2_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic lb_s1_q, lb_s2_q;
    logic wr_s1_q, wr_s2_q, wr_s3_q;
    logic rd_s1_q, rd_s2_q, rd_s3_q;
    logic [15:0] wr_hold_q;
    logic [2:0] rd_hold_q;
    logic ext_sel_q;
    logic low_bat_q;
    logic ready_q;
    logic [15:0] result_q;
    logic [7:0] div_q;
    logic tick_q;
    logic wr_evt, rd_evt, ext_rise;
    mapl_pkg::mapl_stat_t stat_w;

    // Two-stage synchronisers for pins and link toggles
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            lb_s1_q <= 1'b0;
            lb_s2_q <= 1'b0;
            wr_s1_q <= 1'b0;
            wr_s2_q <= 1'b0;
            wr_s3_q <= 1'b0;
            rd_s1_q <= 1'b0;
            rd_s2_q <= 1'b0;
            rd_s3_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            ext_s1_q <= ext_clk;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            lb_s1_q <= low_batt_below;
            lb_s2_q <= lb_s1_q;
            wr_s1_q <= wr_tgl_q;
            wr_s2_q <= wr_s1_q;
            wr_s3_q <= wr_s2_q;
            rd_s1_q <= rd_tgl_q;
            rd_s2_q <= rd_s1_q;
            rd_s3_q <= rd_s2_q;
        end
    end

    assign wr_evt = wr_s2_q ^ wr_s3_q;
    assign rd_evt = rd_s2_q ^ rd_s3_q;
    assign ext_rise = ext_s2_q & ~ext_s3_q;

    // Link holding registers are stable for many ref cycles after a toggle
    always_comb begin
        wr_hold_q = wr_data_q;
        rd_hold_q = rd_addr_q;
    end

    // Control register: clock select, internal clock after reset; the
    // address comes from the held copy, as the command clears on deselect
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_sel_q <= mapl_pkg::EXT_SEL_RST;
        end else if (wr_evt && wr_addr_q == mapl_pkg::ADDR_CTRL) begin
            ext_sel_q <= wr_hold_q[mapl_pkg::CTRL_EXT_BIT];
        end
    end

    // Low battery latch; a new low level wins over a status read clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            low_bat_q <= 1'b0;
        end else if (lb_s2_q) begin
            low_bat_q <= 1'b1;
        end else if (rd_evt && rd_hold_q == mapl_pkg::ADDR_STAT) begin
            low_bat_q <= 1'b0;
        end
    end

    // Result capture and ready flag; reading the result releases it,
    // but a result arriving in the same cycle keeps it set
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ready_q <= 1'b0;
            result_q <= mapl_pkg::WORD_RST;
        end else if (conv_done) begin
            ready_q <= 1'b1;
            result_q <= conv_result;
        end else if (rd_evt && rd_hold_q == mapl_pkg::ADDR_RES) begin
            ready_q <= 1'b0;
        end
    end

    // Snapshots refresh only while deselected so a read frame sees
    // steady words; costs a result that lands mid-frame one frame of lag
    always_comb begin
        stat_w = '0;
        stat_w.low_bat = low_bat_q;
        stat_w.ready = ready_q;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            snap_ctrl_q <= mapl_pkg::WORD_RST;
            snap_stat_q <= mapl_pkg::WORD_RST;
            snap_res_q <= mapl_pkg::WORD_RST;
        end else if (cs_s2_q) begin
            snap_ctrl_q <= {15'h0000, ext_sel_q};
            snap_stat_q <= stat_w;
            snap_res_q <= result_q;
        end
    end

    // Internal oscillator divider, free running
    always_ff @(posedge ref_clk) begin
        if (rst || div_q == 8'h00) begin
            div_q <= DIV_TOP;
        end else begin
            div_q <= div_q - 8'h01;
        end
    end

    // Modulator tick from the selected master clock source
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else if (ext_sel_q) begin
            tick_q <= ext_rise;
        end else begin
            tick_q <= (div_q == 8'h00);
        end
    end

    assign mod_tick = tick_q;
    assign external_clock_select = ext_sel_q;
    assign eoc_n = ~ready_q;
    assign low_batt_lit = low_bat_q;

    // ---------------- Checks ----------------
    a_ext_tick_src: assert property (@(posedge ref_clk) disable iff (rst)
        ext_sel_q && ext_rise |=> mod_tick)
        else $error("external edge did not give a tick");

    a_int_tick_src: assert property (@(posedge ref_clk) disable iff (rst)
        !ext_sel_q && div_q != 8'h00 |=> !mod_tick)
        else $error("tick outside internal divider slot");

    a_low_bat_latch: assert property (@(posedge ref_clk) disable iff (rst)
        lb_s2_q |=> low_batt_lit ##1 (low_batt_lit || $past(rd_evt)))
        else $error("low battery flag not latched");

    a_eoc_on_done: assert property (@(posedge ref_clk) disable iff (rst)
        conv_done |=> !eoc_n && result_q == $past(conv_result))
        else $error("end of conversion not signalled");

    a_idle_counter: assert property (@(posedge ref_clk) disable iff (rst)
        cs_n && $past(cs_n) |-> bit_cnt_q == 5'h00 && !sdo_o)
        else $error("serial port active while deselected");

    a_bit_capture: assert property (@(posedge sclk) disable iff (cs_n)
        bit_cnt_q < mapl_pkg::CMD_LAST |=>
        bit_cnt_q == $past(bit_cnt_q) + 5'h01 && rx_q[0] == $past(sdi))
        else $error("input bit not captured");

    a_msb_out: assert property (@(posedge sclk) disable iff (cs_n)
        cmd_q.rd && bit_cnt_q == mapl_pkg::FIRST_OUT |->
        sdo_o == tx_word[15])
        else $error("first reply bit wrong");

    a_release_out: assert property (@(posedge ref_clk) disable iff (rst)
        cs_n |-> sdo_oe_n && !sdo_o)
        else $error("output driven while deselected");

    a_no_reply: assert property (@(posedge sclk) disable iff (cs_n)
        !cmd_q.rd && bit_cnt_q > mapl_pkg::FIRST_OUT |-> !sdo_o)
        else $error("data sent without read command");

    a_sel_reset: assert property (@(posedge ref_clk)
        rst |=> !external_clock_select)
        else $error("clock select not cleared by reset");

endmodule : mapl_pin_logic
`default_nettype wire

// [mapl_host.sv]
// Host model driving the converter serial port
`timescale 1ns/1ns
`default_nettype none
module mapl_host (
    // Serial pins toward the converter
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe_n
);
    logic [15:0] rdata;
    logic [15:0] oe_bad;
    event done;

    // Deselected and still until a frame starts
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        rdata = 16'h0000;
        oe_bad = 16'h0000;
    end

    // One frame of nb bits, MSB first, 30 ns link period
    task automatic xfer(input logic [23:0] f, input int nb,
                        input logic idle_hi);
        sclk = idle_hi;
        #20 cs_n = 1'b0;
        #150;
        for (int i = 0; i < nb; i++) begin
            if (idle_hi) sclk = 1'b0;
            sdi = f[23-i];
            #15 sclk = 1'b1;
            // Reply bits taken on rises 9..24; a released line reads inverse
            if (i >= 8) rdata = {rdata[14:0], sdo_oe_n ? ~sdo_o : sdo_o};
            if (sdo_oe_n !== 1'b0) oe_bad = oe_bad + 16'h0001;
            #15 if (!idle_hi) sclk = 1'b0;
        end
        // Release after the last edge; released data line shows inverse
        #10 cs_n = 1'b1;
        sdi = ~sdi;
        -> done;
        #200;
    endtask : xfer

    // Clock wiggles with data held low while deselected, must be ignored
    task automatic noise();
        for (int i = 0; i < 24; i++) begin
            sdi = 1'b0;
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
    endtask : noise
endmodule : mapl_host
`default_nettype wire

// [mapl_pin_logic_bench.sv]
// Self-checking bench for the meter converter host-port logic
`timescale 1ns/1ns
`default_nettype none
module mapl_pin_logic_bench;
    logic ref_clk = 1'b0;
    logic rst, low_batt_below, conv_done, ext_run;
    logic ext_clk = 1'b0;
    logic [15:0] conv_result;
    wire logic sclk, cs_n, sdi, sdo_o, sdo_oe_n, eoc_n, low_batt_lit;
    wire logic external_clock_select, mod_tick;
    logic [15:0] expq[$];
    logic [31:0] seed = 32'hbb2ab4b5;
    int num_errors = 0, comparisons = 0, ticks = 0, cycles = 0, ediv = 0;

    always #20 ref_clk = ~ref_clk;

    mapl_pin_logic #(.INT_DIV(5)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o),
        .sdo_oe_n(sdo_oe_n), .ext_clk(ext_clk),
        .low_batt_below(low_batt_below), .conv_done(conv_done),
        .conv_result(conv_result), .eoc_n(eoc_n),
        .low_batt_lit(low_batt_lit),
        .external_clock_select(external_clock_select),
        .mod_tick(mod_tick));
    mapl_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o),
        .sdo_oe_n(sdo_oe_n));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // Read with the expected reply noted for the watcher
    task automatic rd(input logic [2:0] a, input logic [15:0] e,
                      input logic ih);
        expq.push_back(e);
        u_host.xfer({1'b1, a, 4'h0, 16'h0000}, 24, ih);
        cyc(2);
    endtask : rd

    task automatic wr(input logic [2:0] a, input logic [15:0] d,
                      input logic ih);
        u_host.xfer({1'b0, a, 4'h0, d}, 24, ih);
        cyc(6);
    endtask : wr

    // Count master ticks over n cycles and test the range
    task automatic count(input int n, input int lo, input int hi);
        ticks = 0;
        cyc(n);
        chk("tick count in range", 16'h0001,
            {15'h0, ticks >= lo && ticks <= hi});
    endtask : count

    // Each finished read frame's reply against the oldest note
    always @(u_host.done) begin
        if (expq.size() > 0)
            chk("read reply", expq.pop_front(), u_host.rdata);
    end

    always @(posedge ref_clk) begin
        if (mod_tick === 1'b1) ticks = ticks + 1;
        cycles = cycles + 1;
        // Hang guard, well above the roughly 670 cycles of the run
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    // External master clock with a 10-cycle period once enabled
    always @(negedge ref_clk) begin
        if (ext_run) begin
            ediv = ediv + 1;
            if (ediv == 5) begin
                ext_clk <= ~ext_clk;
                ediv = 0;
            end
        end
    end

    initial begin
        rst = 1'b1;
        low_batt_below = 1'b0;
        conv_done = 1'b0;
        conv_result = 16'h0000;
        ext_run = 1'b0;
        cyc(10);
        rst = 1'b0;
        cyc(3);
        chk("eoc_n", 16'h0001, {15'h0, eoc_n});
        chk("clock select", 16'h0000, {15'h0, external_clock_select});
        chk("battery symbol", 16'h0000, {15'h0, low_batt_lit});
        chk("output enable", 16'h0001, {15'h0, sdo_oe_n});
        ext_run = 1'b1;
        count(100, 19, 21);
        // Two fresh results, read with each clock idle level
        for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            conv_result = seed[15:0];
            conv_done = 1'b1;
            cyc(1);
            conv_done = 1'b0;
            chk("eoc_n", 16'h0000, {15'h0, eoc_n});
            cyc(2);
            rd(mapl_pkg::ADDR_RES, conv_result, k[0]);
            cyc(4);
            chk("eoc_n", 16'h0001, {15'h0, eoc_n});
        end
        // Low battery latches until read with the input recovered
        low_batt_below = 1'b1;
        cyc(4);
        chk("battery symbol", 16'h0001, {15'h0, low_batt_lit});
        low_batt_below = 1'b0;
        cyc(4);
        chk("battery symbol", 16'h0001, {15'h0, low_batt_lit});
        rd(mapl_pkg::ADDR_STAT, 16'h0001, 1'b1);
        cyc(4);
        chk("battery symbol", 16'h0000, {15'h0, low_batt_lit});
        rd(mapl_pkg::ADDR_STAT, 16'h0000, 1'b0);
        // External clock mode and refused traffic
        wr(mapl_pkg::ADDR_CTRL, 16'h0001, 1'b0);
        chk("clock select", 16'h0001, {15'h0, external_clock_select});
        count(100, 9, 11);
        rd(mapl_pkg::ADDR_CTRL, 16'h0001, 1'b1);
        u_host.xfer({1'b0, mapl_pkg::ADDR_CTRL, 20'h00000}, 12, 1'b0);
        cyc(6);
        chk("clock select", 16'h0001, {15'h0, external_clock_select});
        u_host.noise();
        cyc(6);
        chk("clock select", 16'h0001, {15'h0, external_clock_select});
        // A write to the status address must leave the control bit alone
        wr(mapl_pkg::ADDR_STAT, 16'h0000, 1'b0);
        chk("clock select", 16'h0001, {15'h0, external_clock_select});
        wr(mapl_pkg::ADDR_CTRL, 16'h0000, 1'b1);
        chk("clock select", 16'h0000, {15'h0, external_clock_select});
        count(100, 19, 21);
        rd(3'h5, 16'h0000, 1'b0);
        chk("enable in frame", 16'h0000, u_host.oe_bad);
        chk("replies pending", 16'h0000, 16'(expq.size()));
        print_verdict();
    end
endmodule : mapl_pin_logic_bench
`default_nettype wire
